// file: rtl/chec_event_counters.sv
// Event counters of the configuration hub with Wishbone slave and interrupt
`include "chec_params.svh"
`timescale 1ns/1ps
`default_nettype none

module chec_event_counters
  import chec_pkg::*;
#(
  parameter int CNT_W = 48,
  parameter int N_EVENTS = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [N_EVENTS-1:0] event_i, // Event strobes, same clock
  output logic irq_o // Level interrupt
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  initial begin
    if (CNT_W < 33 || CNT_W > 64) $error("CNT_W out of range");
    if (N_EVENTS < 1 || N_EVENTS > 256) $error("N_EVENTS out of range");
  end

  localparam int NP = 2;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic [31:0] wmask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  chec_req_t req;
  logic acc, wr;
  logic [31:0] m, wd;
  assign req = '{addr: wb_adr_i[7:2], we: wb_we_i, sel: wb_sel_i, data: wb_dat_i};
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && req.we;
  assign m = wmask(req.sel);
  assign wd = req.data & m;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // ****************************************
  // Global control
  // ****************************************
  logic frz_q;
  logic gctl_wr, rst_cnt;
  assign gctl_wr = wr && hit(wb_adr_i, `CHEC_OFF_GCTL) && req.sel[0];
  assign rst_cnt = gctl_wr && req.data[`CHEC_GCTL_RST];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frz_q <= `CHEC_FRZ_RST;
    end else if (gctl_wr) begin
      if (req.data[`CHEC_GCTL_FRZ]) begin
        frz_q <= 1'b1;
      end else if (req.data[`CHEC_GCTL_UNFRZ]) begin
        frz_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Fixed counter
  // ****************************************
  chec_ctl_t fctl_q;
  logic [CNT_W-1:0] fcnt_q;
  logic [CNT_W:0] fsum;
  logic fov;
  logic [63:0] fwide;
  assign fsum = {1'b0, fcnt_q} + {{CNT_W{1'b0}}, 1'b1};
  assign fov = fctl_q.en && !frz_q && fsum[CNT_W];
  assign fwide = 64'(fcnt_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fctl_q <= '0;
    end else if (wr && hit(wb_adr_i, `CHEC_OFF_FCTL) && req.sel[2]) begin
      fctl_q.en <= req.data[`CHEC_FCTL_EN];
      fctl_q.overflow_report_enable <= req.data[`CHEC_FCTL_OVEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rst_cnt) begin
      fcnt_q <= `CHEC_RST_CNT;
    end else if (wr && hit(wb_adr_i, `CHEC_OFF_FVAL_LO)) begin
      fcnt_q[31:0] <= (fcnt_q[31:0] & ~m) | wd;
    end else if (wr && hit(wb_adr_i, `CHEC_OFF_FVAL_HI)) begin
      // upper bits reserved
      // Only the count bits above 31 are kept
      fcnt_q[CNT_W-1:32] <= (CNT_W-32)'((fwide[63:32] & ~m) | wd);
    end else if (fctl_q.en && !frz_q) begin
      fcnt_q <= fsum[CNT_W-1:0];
    end
  end

  // ****************************************
  // Programmable counters
  // ****************************************
  chec_ctl_t pctl_q [NP];
  logic [CNT_W-1:0] pcnt_q [NP];
  logic [NP-1:0] pov;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_prog
      logic [7:0] o_ctl, o_lo, o_hi;
      logic [CNT_W:0] psum;
      logic inc;
      logic [63:0] pwide;
      assign o_ctl = `CHEC_OFF_PCTL0 + 8'(g * 12);
      assign o_lo = `CHEC_OFF_PVAL0_LO + 8'(g * 12);
      assign o_hi = `CHEC_OFF_PVAL0_HI + 8'(g * 12);
      assign inc = pctl_q[g].en && !frz_q && (int'(pctl_q[g].ev_sel) < N_EVENTS) &&
                   event_i[pctl_q[g].ev_sel[$clog2(N_EVENTS+1)-1:0] % N_EVENTS];
      assign psum = {1'b0, pcnt_q[g]} + {{CNT_W{1'b0}}, 1'b1};
      // Carry out of the top bit on a counting step
      assign pov[g] = inc && (&pcnt_q[g]);
      assign pwide = 64'(pcnt_q[g]);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pctl_q[g] <= '0;
        end else if (wr && hit(wb_adr_i, o_ctl)) begin
          if (req.sel[2]) begin
            pctl_q[g].en <= req.data[`CHEC_PCTL_EN];
            pctl_q[g].overflow_report_enable <= req.data[`CHEC_PCTL_OVEN];
          end
          if (req.sel[0]) begin
            pctl_q[g].ev_sel <= req.data[7:0];
          end
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i || rst_cnt) begin
          pcnt_q[g] <= `CHEC_RST_CNT;
        // Bus write wins over counting
        end else if (wr && hit(wb_adr_i, o_lo)) begin
          pcnt_q[g][31:0] <= (pcnt_q[g][31:0] & ~m) | wd;
        end else if (wr && hit(wb_adr_i, o_hi)) begin
          pcnt_q[g][CNT_W-1:32] <= (CNT_W-32)'((pwide[63:32] & ~m) | wd);
        end else if (inc) begin
          pcnt_q[g] <= psum[CNT_W-1:0];
        end
      end
    end
  endgenerate

  logic [NP-1:0] pcarry;
  generate
    for (g = 0; g < NP; g++) begin : g_carry
      // Carry reported only with report enable
      assign pcarry[g] = pov[g] && pctl_q[g].overflow_report_enable;
    end
  endgenerate

  // ****************************************
  // Overflow flags and interrupt
  // ****************************************
  logic [NP:0] flags_q, mask_q, set_v, clr_v;
  assign set_v = {pcarry, fov && fctl_q.overflow_report_enable};
  assign clr_v = (wr && hit(wb_adr_i, `CHEC_OFF_GFLAGS) && req.sel[0]) ? req.data[NP:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr_v) | set_v;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (wr && hit(wb_adr_i, `CHEC_OFF_INTMASK) && req.sel[0]) begin
      mask_q <= req.data[NP:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_q & mask_q);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  function automatic logic [31:0] ctl_word(input chec_ctl_t c);
    logic [31:0] w;
    w = '0;
    w[`CHEC_FCTL_EN] = c.en;
    w[`CHEC_FCTL_OVEN] = c.overflow_report_enable;
    w[7:0] = c.ev_sel;
    return w;
  endfunction

  // Unmapped offsets read zero
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    case (wb_adr_i)
      `CHEC_OFF_GCTL: rd = 32'(frz_q);
      `CHEC_OFF_GFLAGS: rd = 32'(flags_q);
      `CHEC_OFF_INTMASK: rd = 32'(mask_q);
      `CHEC_OFF_FCTL: rd = ctl_word('{en: fctl_q.en, overflow_report_enable: fctl_q.overflow_report_enable, ev_sel: 8'h00});
      `CHEC_OFF_FVAL_LO: rd = fwide[31:0];
      `CHEC_OFF_FVAL_HI: rd = fwide[63:32];
      `CHEC_OFF_PCTL0: rd = ctl_word(pctl_q[0]);
      `CHEC_OFF_PVAL0_LO: rd = 32'(pcnt_q[0]);
      `CHEC_OFF_PVAL0_HI: rd = 32'(pcnt_q[0] >> 32);
      `CHEC_OFF_PCTL1: rd = ctl_word(pctl_q[1]);
      `CHEC_OFF_PVAL1_LO: rd = 32'(pcnt_q[1]);
      `CHEC_OFF_PVAL1_HI: rd = 32'(pcnt_q[1] >> 32);
      default: rd = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    // Read data held until the next read
    end else if (acc && !req.we) begin
      wb_dat_o <= rd;
    end
  end

endmodule

`default_nettype wire

// file: include/chec_params.svh
// Register offsets, field positions and reset values of the event counters
`ifndef CHEC_PARAMS_SVH
`define CHEC_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CHEC_OFF_GCTL     8'h00
`define CHEC_OFF_GFLAGS   8'h04
`define CHEC_OFF_INTMASK  8'h08
`define CHEC_OFF_FCTL     8'h0C
`define CHEC_OFF_FVAL_LO  8'h10
`define CHEC_OFF_FVAL_HI  8'h14
`define CHEC_OFF_PCTL0    8'h18
`define CHEC_OFF_PVAL0_LO 8'h1C
`define CHEC_OFF_PVAL0_HI 8'h20
`define CHEC_OFF_PCTL1    8'h24
`define CHEC_OFF_PVAL1_LO 8'h28
`define CHEC_OFF_PVAL1_HI 8'h2C
`define CHEC_OFF_EVENTS   8'h30

// ****************************************
// Field positions
// ****************************************
`define CHEC_GCTL_FRZ     0
`define CHEC_GCTL_UNFRZ   1
`define CHEC_GCTL_RST     2
`define CHEC_FCTL_OVEN    20
`define CHEC_FCTL_RSV     21
`define CHEC_FCTL_EN      22
`define CHEC_PCTL_EVSEL_LO 0
`define CHEC_PCTL_OVEN    20
`define CHEC_PCTL_EN      22
`define CHEC_FLAG_FIXED   0
`define CHEC_FLAG_PROG0   1

// ****************************************
// Reset values
// ****************************************
`define CHEC_RST_CTL      32'h0000_0000
`define CHEC_RST_CNT      48'h0000_0000_0000
`define CHEC_FRZ_RST      1'b1

`endif

// file: include/chec_pkg.sv
// Types shared by the event counter block
package chec_pkg;

  typedef struct packed {
    logic [5:0] addr;
    logic we;
    logic [3:0] sel;
    logic [31:0] data;
  } chec_req_t;

  typedef struct packed {
    logic en;
    logic overflow_report_enable;
    logic [7:0] ev_sel;
  } chec_ctl_t;

endpackage

// file: tb/chec_event_counters_asserts.sv
// Port assertions for the event counters
`include "chec_params.svh"
`timescale 1ns/1ps
`default_nettype none
module chec_event_counters_asserts #(
  parameter int CNT_W = 48,
  parameter int N_EVENTS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [N_EVENTS-1:0] event_i,
  input wire logic irq_o
);
  logic rd_q;
  logic [7:0] a_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Remember a read request and its address
  always_ff @(posedge clk_i) begin
    rd_q <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && !rst_i;
    a_q <= wb_adr_i;
  end
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  hi_zero_a: assert property (wb_ack_o && rd_q && a_q inside {`CHEC_OFF_FVAL_HI, `CHEC_OFF_PVAL0_HI,
    `CHEC_OFF_PVAL1_HI} |-> wb_dat_o[31:16] == 16'h0) else $error("count high bits set");
  fctl_rsv_a: assert property (wb_ack_o && rd_q && a_q == `CHEC_OFF_FCTL |-> (wb_dat_o & 32'hFFAF_FFFF) == 0)
    else $error("fixed control reserved set");
  flag_rsv_a: assert property (wb_ack_o && rd_q && a_q == `CHEC_OFF_GFLAGS |-> wb_dat_o[31:3] == 0)
    else $error("flag reserved set");
  unmap_zero_a: assert property (wb_ack_o && rd_q && a_q >= `CHEC_OFF_EVENTS |-> wb_dat_o == 0)
    else $error("unmapped read nonzero");
  reset_quiet_a: assert property ($fell(rst_i) |-> !irq_o && !wb_ack_o) else $error("busy after reset");
endmodule
bind chec_event_counters chec_event_counters_asserts #(.CNT_W(CNT_W), .N_EVENTS(N_EVENTS)) i_chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .event_i, .irq_o);
`default_nettype wire

// file: tb/chec_event_counters_test.sv
// Self-checking bench for the event counters
`include "chec_params.svh"
`timescale 1ns/1ps
`default_nettype none
module chec_event_counters_test;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [7:0] ev = 8'h00;
  logic [31:0] lfsr_q = 32'hFD98;
  wire logic [31:0] rdat;
  wire logic ack;
  wire logic irq;
  int num_errors = 0;
  int cmp_count = 0;
  logic frz_m;
  logic irq_m;
  logic [2:0] flg_m;
  logic [2:0] msk_m;
  logic [31:0] ctl_m [3];
  logic [47:0] cnt_m [3];
  always #12.5 clk_i = ~clk_i;
  chec_event_counters i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .event_i(ev), .irq_o(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk_i) begin
    lfsr_q <= lfsr(lfsr_q);
    ev <= lfsr_q[7:0];
  end
  // ****************************************
  // Reference model
  // ****************************************
  task automatic step(input int i, input logic inc);
    if (inc && !frz_m) begin
      cnt_m[i] = cnt_m[i] + 48'h1;
      if (cnt_m[i] == 0 && ctl_m[i][20]) flg_m[i] = 1;
    end
  endtask
  function automatic logic [31:0] rd_m(input logic [7:0] a);
    int i;
    i = (a - 16) / 12;
    if (a == `CHEC_OFF_GCTL) return {31'h0, frz_m};
    if (a == `CHEC_OFF_GFLAGS) return {29'h0, flg_m};
    if (a == `CHEC_OFF_INTMASK) return {29'h0, msk_m};
    if (a == `CHEC_OFF_FCTL) return ctl_m[0];
    if (a < 8'h10 || a >= 8'h30) return 0;
    if ((a - 16) % 12 == 0) return cnt_m[i][31:0];
    if ((a - 16) % 12 == 4) return {16'h0, cnt_m[i][47:32]};
    return ctl_m[i + 1];
  endfunction
  task automatic wr_m(input logic [7:0] a, input logic [31:0] d);
    int i;
    i = (a - 16) / 12;
    if (a == `CHEC_OFF_GCTL) begin
      if (d[2]) cnt_m = '{default: 0};
      if (d[0]) frz_m = 1;
      else if (d[1]) frz_m = 0;
    end else if (a == `CHEC_OFF_GFLAGS) flg_m &= ~d[2:0];
    else if (a == `CHEC_OFF_INTMASK) msk_m = d[2:0];
    else if (a == `CHEC_OFF_FCTL) ctl_m[0] = d & 32'h0050_0000;
    else if (a >= 8'h10 && a < 8'h30) begin
      if ((a - 16) % 12 == 0) cnt_m[i][31:0] = d;
      else if ((a - 16) % 12 == 4) cnt_m[i][47:32] = d[15:0];
      else ctl_m[i + 1] = d & 32'h0050_00FF;
    end
  endtask
  always @(posedge clk_i) begin
    if (rst_i) begin
      frz_m = 1;
      irq_m = 0;
      flg_m = 0;
      msk_m = 0;
      ctl_m = '{default: 0};
      cnt_m = '{default: 0};
    end else begin
      irq_m = |(flg_m & msk_m);
      step(0, ctl_m[0][22]);
      for (int k = 1; k < 3; k++) step(k, ctl_m[k][22] && ctl_m[k][7:0] < 8 && ev[ctl_m[k][2:0]]);
      if (cyc && stb && !ack && we) wr_m(adr, wdat);
    end
  end
  // ****************************************
  // Bus and checking tasks
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    q = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask
  task automatic rd_all();
    logic [31:0] q;
    for (int a = 0; a < 64; a += 4) begin
      bus(0, a[7:0], 0, q);
      chk($sformatf("reg %h", a[7:0]), q, rd_m(a[7:0]));
    end
    chk("irq", {31'h0, irq}, {31'h0, irq_m});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rd_all();
    for (int a = 8; a < 48; a += 4) wr(a[7:0], lfsr_q & 32'hFFDF_FFFF);
    rd_all();
    for (int r = 0; r < 4; r++) begin
      wr(`CHEC_OFF_GCTL, 32'h4);
      wr(`CHEC_OFF_GFLAGS, 32'h7);
      rd_all();
      wr(`CHEC_OFF_FCTL, 32'h0050_0000);
      wr(`CHEC_OFF_PCTL0, 32'h0050_0000 | r);
      wr(`CHEC_OFF_PCTL1, 32'h0050_0004 + 32'(r * 2));
      wr(`CHEC_OFF_INTMASK, lfsr_q);
      for (int i = 0; i < 3; i++) begin
        wr(8'(16 + 12 * i), 32'hFFFF_FFEC + 32'(4 * i));
        wr(8'(20 + 12 * i), 32'h0000_FFFF);
      end
      wr(`CHEC_OFF_GCTL, 32'h2);
      repeat (30) @(posedge clk_i);
      wr(`CHEC_OFF_GCTL, 32'h3);
      repeat (8) @(posedge clk_i);
      rd_all();
    end
    stop_test();
  end
endmodule
`default_nettype wire
